// *** pkg/css_pkg.sv ***
// Overview of operation
// - charger bit 7 is OR of faults
// - live flag rises 80 ms after enable
// - live flag falls on disable or refresh end
// - live means all measurements made once
// - phase field bits 5:3, codes 0-4
// - phase holds its value during fault unless logic is off or a restart comes
// - phase clears on off, reset, restart
// - active flag set during phases 0-3
// - active flag clear when off/fault/done/unstarted
// - bit 1 shows current above C/10
// - logic-enabled flag sets at once
// - logic-enabled flag clears 6 ms after disable
// - enabled logic blocks restricted byte writes
// - startup-ok shows good boot copy
// - bit 4 flags factory checksum failure
// - boot checksum failure flag
// - status bit mirrors switcher enable pin
// - busy field 00 idle, 01 startup, 10 long
// - busy blocks restricted byte writes
// - read-only bytes at 0x12 and 0x13
package css_pkg;
   localparam int         CLK_HZ          = 25_000_000;
   localparam int         LIVE_DELAY_MS   = 80;
   localparam int         LIVE_DELAY_CYC  = LIVE_DELAY_MS * (CLK_HZ / 1000);
   localparam int         OFF_DELAY_MS    = 6;
   localparam int         OFF_DELAY_CYC   = OFF_DELAY_MS * (CLK_HZ / 1000);
   localparam int         CNT_W           = 21;
   localparam logic [7:0] ADDR_CHG_STATUS = 8'h12;
   localparam logic [7:0] ADDR_SYS_STATUS = 8'h13;
   // charger status fields
   localparam int         CHG_FAULT_BIT   = 7;
   localparam int         CHG_LIVE_BIT    = 6;
   localparam int         CHG_PHASE_LSB   = 3;
   localparam int         CHG_ACTIVE_BIT  = 2;
   localparam int         CHG_ABOVE_BIT   = 1;
   localparam int         CHG_LOGIC_BIT   = 0;
   // system status fields
   localparam int         SYS_BOOT_OK_BIT = 5;
   localparam int         SYS_FACT_BIT    = 4;
   localparam int         SYS_BOOTERR_BIT = 3;
   localparam int         SYS_SWEN_BIT    = 2;
   localparam logic [2:0] PHASE_0         = 3'h0;
   localparam logic [2:0] PHASE_DONE      = 3'h4;
   localparam logic [1:0] BUSY_IDLE       = 2'h0;
   localparam logic [1:0] BUSY_STARTUP    = 2'h1;
   localparam logic [1:0] BUSY_LONG       = 2'h2;
   localparam logic [7:0] RESET_BYTE      = 8'h00;
endpackage : css_pkg

// *** hdl/css_status_regs.sv ***
`timescale 1ns/1ps
module css_status_regs
   import css_pkg::*;
#(
   parameter int LIVE_CYC = LIVE_DELAY_CYC,
   parameter int OFF_CYC  = OFF_DELAY_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        rd_en,
   input  wire logic [7:0]  rd_addr,
   output logic      [7:0]  rd_data_r,
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_addr,
   input  wire logic        wr_restricted,
   output logic             wr_accept,
   input  wire logic [7:0]  fault_source_register,
   input  wire logic        charge_enable_request,
   input  wire logic        telemetry_refresh_command,
   input  wire logic        telemetry_refresh_done,
   input  wire logic        phase_load,
   input  wire logic [2:0]  phase_code,
   input  wire logic        phase_restart,
   input  wire logic [15:0] output_current_reading,
   input  wire logic [15:0] tenth_capacity_current,
   input  wire logic        startup_done,
   input  wire logic        boot_copy_ok,
   input  wire logic        factory_crc_fail,
   input  wire logic        boot_crc_fail,
   input  wire logic        nv_write_active,
   input  wire logic        switcher_enable_pin
);

   logic             fault_r, fault_nxt;
   logic             en_prev_r, en_prev_nxt;
   logic             live_r, live_nxt;
   logic [CNT_W-1:0] live_cnt_r, live_cnt_nxt;
   logic             refresh_r, refresh_nxt;
   logic             logic_en_r, logic_en_nxt;
   logic [CNT_W-1:0] off_cnt_r, off_cnt_nxt;
   logic [2:0]       phase_r, phase_nxt;
   logic             started_r, started_nxt;
   logic             above_r, above_nxt;
   logic             startup_busy_r, startup_busy_nxt;
   logic             boot_ok_r, boot_ok_nxt;
   logic             fact_err_r, fact_err_nxt;
   logic             boot_err_r, boot_err_nxt;
   logic             swen_meta_r, swen_r;
   logic [7:0]       rd_data_nxt;
   logic             charging_active;
   logic [1:0]       busy;
   logic [7:0]       chg_status, sys_status;

   // pin is asynchronous to sys_clk; the first stage feeds only the second
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         swen_meta_r <= 1'b0;
         swen_r      <= 1'b0;
      end else begin
         swen_meta_r <= switcher_enable_pin;
         swen_r      <= swen_meta_r;
      end
   end

   // enable tracking, telemetry-live flag and logic-enabled flag
   always_comb begin
      en_prev_nxt  = charge_enable_request;
      fault_nxt    = |fault_source_register;
      live_nxt     = live_r;
      live_cnt_nxt = live_cnt_r;
      refresh_nxt  = refresh_r;
      logic_en_nxt = logic_en_r;
      off_cnt_nxt  = off_cnt_r;
      // the enable delay restarts on every 0->1 edge so all readings are fresh
      if (charge_enable_request && !en_prev_r) begin
         live_cnt_nxt = CNT_W'(LIVE_CYC);
      end else if (charge_enable_request && live_cnt_r != '0) begin
         live_cnt_nxt = live_cnt_r - 1'b1;
         if (live_cnt_r == CNT_W'(1)) begin
            live_nxt = 1'b1;
         end
      end
      if (!charge_enable_request) begin
         live_cnt_nxt = '0;
         if (en_prev_r) begin
            live_nxt = 1'b0;
         end
      end
      if (telemetry_refresh_done && refresh_r) begin
         refresh_nxt = 1'b0;
         live_nxt    = 1'b0;
      end
      // a new refresh request wins over a finish in the same cycle
      if (telemetry_refresh_command) begin
         refresh_nxt = 1'b1;
         live_nxt    = 1'b1;
      end
      if (charge_enable_request) begin
         logic_en_nxt = 1'b1;
         off_cnt_nxt  = CNT_W'(OFF_CYC);
      end else if (logic_en_r) begin
         if (off_cnt_r <= CNT_W'(1)) begin
            logic_en_nxt = 1'b0;
            off_cnt_nxt  = '0;
         end else begin
            off_cnt_nxt = off_cnt_r - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_r    <= 1'b0;
         en_prev_r  <= 1'b0;
         live_r     <= 1'b0;
         live_cnt_r <= '0;
         refresh_r  <= 1'b0;
         logic_en_r <= 1'b0;
         off_cnt_r  <= '0;
      end else begin
         fault_r    <= fault_nxt;
         en_prev_r  <= en_prev_nxt;
         live_r     <= live_nxt;
         live_cnt_r <= live_cnt_nxt;
         refresh_r  <= refresh_nxt;
         logic_en_r <= logic_en_nxt;
         off_cnt_r  <= off_cnt_nxt;
      end
   end

   // charge phase tracking and current threshold
   always_comb begin
      phase_nxt   = phase_r;
      started_nxt = started_r;
      above_nxt   = output_current_reading > tenth_capacity_current;
      if (!logic_en_r || phase_restart) begin
         phase_nxt   = PHASE_0;
         started_nxt = logic_en_r && phase_restart;
      end else if (fault_r) begin
         phase_nxt = phase_r;
      end else if (phase_load && phase_code <= PHASE_DONE) begin
         phase_nxt   = phase_code;
         started_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r   <= PHASE_0;
         started_r <= 1'b0;
         above_r   <= 1'b0;
      end else begin
         phase_r   <= phase_nxt;
         started_r <= started_nxt;
         above_r   <= above_nxt;
      end
   end

   // startup results latch each time the startup sequence reports done
   always_comb begin
      startup_busy_nxt = startup_busy_r;
      boot_ok_nxt      = boot_ok_r;
      fact_err_nxt     = fact_err_r;
      boot_err_nxt     = boot_err_r;
      if (startup_done) begin
         startup_busy_nxt = 1'b0;
         boot_ok_nxt      = boot_copy_ok && !boot_crc_fail;
         fact_err_nxt     = factory_crc_fail;
         boot_err_nxt     = boot_crc_fail;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         startup_busy_r <= 1'b1;
         boot_ok_r      <= 1'b0;
         fact_err_r     <= 1'b0;
         boot_err_r     <= 1'b0;
      end else begin
         startup_busy_r <= startup_busy_nxt;
         boot_ok_r      <= boot_ok_nxt;
         fact_err_r     <= fact_err_nxt;
         boot_err_r     <= boot_err_nxt;
      end
   end

   // status assembly; busy never takes code 11
   assign charging_active = logic_en_r && !fault_r && started_r && phase_r != PHASE_DONE;
   assign busy = startup_busy_r ? BUSY_STARTUP :
                 (refresh_r || nv_write_active) ? BUSY_LONG : BUSY_IDLE;

   always_comb begin
      chg_status                                  = RESET_BYTE;
      chg_status[CHG_FAULT_BIT]                   = fault_r;
      chg_status[CHG_LIVE_BIT]                    = live_r;
      chg_status[CHG_PHASE_LSB +: 3]              = phase_r;
      chg_status[CHG_ACTIVE_BIT]                  = charging_active;
      chg_status[CHG_ABOVE_BIT]                   = above_r;
      chg_status[CHG_LOGIC_BIT]                   = logic_en_r;
      sys_status                                  = RESET_BYTE;
      sys_status[SYS_BOOT_OK_BIT]                 = boot_ok_r;
      sys_status[SYS_FACT_BIT]                    = fact_err_r;
      sys_status[SYS_BOOTERR_BIT]                 = boot_err_r;
      sys_status[SYS_SWEN_BIT]                    = swen_r;
      sys_status[1:0]                             = busy;
   end

   // read port; unmapped addresses read zero
   always_comb begin
      rd_data_nxt = rd_data_r;
      if (rd_en) begin
         unique case (rd_addr)
            ADDR_CHG_STATUS: rd_data_nxt = chg_status;
            ADDR_SYS_STATUS: rd_data_nxt = sys_status;
            default:         rd_data_nxt = RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= RESET_BYTE;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   // status bytes are never writable; restricted writes wait for idle logic
   assign wr_accept = wr_en && wr_addr != ADDR_CHG_STATUS && wr_addr != ADDR_SYS_STATUS
                      && !(wr_restricted && (logic_en_r || busy != BUSY_IDLE));

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_fault_summary_set: assert property (|fault_source_register |=> fault_r)
      else $error("fault summary missed a fault source");
   a_live_on_refresh: assert property (telemetry_refresh_command |=> live_r && busy != BUSY_IDLE)
      else $error("refresh did not raise live flag");
   a_live_disable_drop: assert property ($fell(charge_enable_request) && !telemetry_refresh_command |=> !live_r)
      else $error("live flag stayed after disable");
   a_logic_on_now: assert property (charge_enable_request |=> logic_en_r)
      else $error("logic enabled flag late");
   a_phase_off_zero: assert property (!logic_en_r |=> phase_r == PHASE_0)
      else $error("phase not cleared while logic off");
   a_phase_fault_hold: assert property (fault_r && charge_enable_request && logic_en_r && !phase_restart
                                        |=> phase_r == $past(phase_r))
      else $error("phase moved during fault");
   a_active_blocked: assert property (charging_active |-> logic_en_r && !fault_r && phase_r <= 3'h3)
      else $error("active flag set in a stopped state");
   a_busy_code_legal: assert property (busy != 2'h3 && phase_r <= PHASE_DONE)
      else $error("illegal busy or phase code");
   a_current_threshold: assert property (output_current_reading > tenth_capacity_current |=> above_r)
      else $error("current flag not set");
   a_write_blocked: assert property (wr_restricted && logic_en_r |-> !wr_accept)
      else $error("restricted write accepted while enabled");

endmodule : css_status_regs

// *** verif/css_host_model.sv ***
`timescale 1ns/1ps
// serial host reading the status bytes; notes each expected byte as it asks
module css_host_model (
   input  wire logic       sys_clk,
   output logic            rd_en,
   output logic      [7:0] rd_addr
);
   logic [7:0] exp_q[$];
   initial begin
      rd_en   = 1'b0;
      rd_addr = 8'h00;
   end
   // address held through the strobe edge, then scrambled so stale values never look valid
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      @(negedge sys_clk);
      rd_en   = 1'b1;
      rd_addr = addr;
      exp_q.push_back(exp);
      @(negedge sys_clk);
      rd_en   = 1'b0;
      rd_addr = ~addr;
   endtask : rd
endmodule : css_host_model

// *** verif/charger_system_status_regs_bench.sv ***
`timescale 1ns/1ps
module charger_system_status_regs_bench;
   import css_pkg::*;
   localparam int LIVE = 20;
   localparam int OFF  = 10;
   logic        sys_clk, rst_n, rd_en, wr_en, wr_restricted, wr_accept, pend;
   logic        en_req, ref_cmd, ref_done, ph_load, ph_restart, st_done, boot_ok, fact_fail, boot_fail, nv_wr, sw_pin;
   logic [7:0]  rd_addr, rd_data_r, wr_addr, faults, exp_v;
   logic [2:0]  ph_code;
   logic [15:0] i_out, i_tenth;
   logic [31:0] seed;
   int          errors, n_checks, cyc;

   css_host_model css_host_model_inst (.sys_clk(sys_clk), .rd_en(rd_en), .rd_addr(rd_addr));
   css_status_regs #(.LIVE_CYC(LIVE), .OFF_CYC(OFF)) css_status_regs_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_restricted(wr_restricted), .wr_accept(wr_accept),
      .fault_source_register(faults), .charge_enable_request(en_req), .telemetry_refresh_command(ref_cmd),
      .telemetry_refresh_done(ref_done), .phase_load(ph_load), .phase_code(ph_code), .phase_restart(ph_restart),
      .output_current_reading(i_out), .tenth_capacity_current(i_tenth), .startup_done(st_done),
      .boot_copy_ok(boot_ok), .factory_crc_fail(fact_fail), .boot_crc_fail(boot_fail),
      .nv_write_active(nv_wr), .switcher_enable_pin(sw_pin));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : settle

   // write attempt; accept is combinational so it is looked at within the same cycle
   task automatic wchk(input logic [7:0] a, input logic r, input logic e);
      @(negedge sys_clk);
      wr_en = 1'b1;
      wr_addr = a;
      wr_restricted = r;
      #1 chk({7'h0, wr_accept}, {7'h0, e});
      @(negedge sys_clk);
      wr_en = 1'b0;
   endtask : wchk

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs

   // read data lands one edge after the strobe; compare against the oldest note
   always @(posedge sys_clk) pend <= rd_en;
   always @(negedge sys_clk) begin
      if (pend) begin
         exp_v = css_host_model_inst.exp_q.pop_front();
         chk(rd_data_r, exp_v);
      end
   end

   // hang guard, well above the roughly 140 cycles the tests need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         complete_run();
      end
   end

   initial begin
      {rst_n, wr_en, wr_restricted, en_req, ref_cmd, ref_done, ph_load, ph_restart} = 8'h00;
      {st_done, boot_ok, fact_fail, boot_fail, nv_wr, sw_pin} = 6'h00;
      {wr_addr, faults, ph_code, i_out} = 35'h0;
      i_tenth = 16'h0001;
      seed = 32'h4e;
      settle(12);
      rst_n = 1'b1;
      css_host_model_inst.rd(8'h13, 8'h01);
      css_host_model_inst.rd(8'h12, 8'h00);
      css_host_model_inst.rd(8'h20, 8'h00);
      wchk(8'h05, 1'b1, 1'b0);
      $display("test reset done");
      st_done = 1'b1; boot_ok = 1'b1; fact_fail = 1'b1;
      settle(1);
      st_done = 1'b0; sw_pin = 1'b1;
      settle(4);
      css_host_model_inst.rd(8'h13, 8'h34);
      wchk(8'h05, 1'b1, 1'b1);
      wchk(ADDR_CHG_STATUS, 1'b0, 1'b0);
      wchk(ADDR_SYS_STATUS, 1'b0, 1'b0);
      $display("test startup done");
      en_req = 1'b1;
      settle(2);
      css_host_model_inst.rd(8'h12, 8'h01);
      wchk(8'h05, 1'b1, 1'b0);
      settle(LIVE - 12);
      css_host_model_inst.rd(8'h12, 8'h01);
      settle(8);
      css_host_model_inst.rd(8'h12, 8'h41);
      ph_load = 1'b1; ph_code = 3'h1;
      settle(1);
      ph_load = 1'b0;
      settle(2);
      css_host_model_inst.rd(8'h12, 8'h4d);
      // the fault flag is registered, so it must be up before the load for the phase to freeze
      faults = 8'h04;
      settle(1);
      ph_load = 1'b1;
      ph_code = 3'h2;
      settle(1);
      ph_load = 1'b0;
      settle(2);
      css_host_model_inst.rd(8'h12, 8'hc9);
      // let the fault flag drop first, otherwise the load is still held off
      faults = 8'h00;
      settle(1);
      ph_load = 1'b1;
      ph_code = 3'h4;
      settle(1);
      ph_code = 3'h6;
      settle(1);
      ph_load = 1'b0;
      settle(2);
      css_host_model_inst.rd(8'h12, 8'h61);
      ph_restart = 1'b1;
      settle(1);
      ph_restart = 1'b0;
      settle(2);
      css_host_model_inst.rd(8'h12, 8'h45);
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         i_out = seed[15:0];
         i_tenth = (seed[31:16] == seed[15:0]) ? seed[31:16] + 16'h0001 : seed[31:16];
         settle(2);
         css_host_model_inst.rd(8'h12, {6'h11, i_out > i_tenth, 1'b1});
      end
      $display("test charging done");
      i_out = 16'h0000;
      en_req = 1'b0;
      settle(2);
      css_host_model_inst.rd(8'h12, 8'h05);
      settle(OFF + 4);
      css_host_model_inst.rd(8'h12, 8'h00);
      $display("test disable done");
      ref_cmd = 1'b1;
      settle(1);
      ref_cmd = 1'b0;
      settle(1);
      css_host_model_inst.rd(8'h12, 8'h40);
      css_host_model_inst.rd(8'h13, 8'h36);
      wchk(8'h05, 1'b1, 1'b0);
      ref_done = 1'b1;
      settle(1);
      ref_done = 1'b0;
      settle(2);
      css_host_model_inst.rd(8'h12, 8'h00);
      css_host_model_inst.rd(8'h13, 8'h34);
      nv_wr = 1'b1;
      settle(2);
      css_host_model_inst.rd(8'h13, 8'h36);
      nv_wr = 1'b0;
      $display("test busy done");
      settle(3);
      complete_run();
   end
endmodule : charger_system_status_regs_bench
